/* File: src/tcp_defines.svh */
// Register offsets, field positions and reset values of the timer block
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH
`define TCP_A_SC        8'h00
`define TCP_A_CNTH      8'h01
`define TCP_A_CNTL      8'h02
`define TCP_A_MODH      8'h03
`define TCP_A_MODL      8'h04
`define TCP_A_PUE       8'h05
`define TCP_A_CH0       8'h10
`define TCP_CH_STRIDE   8'h04
`define TCP_SUB_SC      2'h0
`define TCP_SUB_VH      2'h1
`define TCP_SUB_VL      2'h2
`define TCP_SC_OVF      7
`define TCP_SC_OVIE     6
`define TCP_SC_CENTER   5
`define TCP_SC_SRC      3
`define TCP_CS_FLAG     7
`define TCP_CS_IE       6
`define TCP_CS_MS       4
`define TCP_CS_EDGE     2
`define TCP_RST_BYTE    8'h00
`define TCP_RST_WORD    16'h0000
`define TCP_CNT_FULL    16'hFFFF
`endif

/* File: src/tcp_pkg.sv */
// Types shared by the timer block modules
package tcp_pkg;
  typedef enum logic [1:0] {TCP_M_CAPTURE, TCP_M_COMPARE, TCP_M_EPWM, TCP_M_CENTER} tcp_mode_t;
  typedef enum logic [1:0] {TCP_SRC_OFF, TCP_SRC_BUS, TCP_SRC_FIXED, TCP_SRC_EXT} tcp_src_t;
  typedef enum logic {TCP_UP, TCP_DOWN} tcp_dir_t;

  function automatic tcp_mode_t tcp_mode(input logic center, input logic [1:0] ms);
    if (center)
      return TCP_M_CENTER;
    else if (ms[1])
      return TCP_M_EPWM;
    else if (ms[0])
      return TCP_M_COMPARE;
    else
      return TCP_M_CAPTURE;
  endfunction : tcp_mode
endpackage : tcp_pkg

/* File: src/tcp_chan_if.sv */
// Link between the shared counter and one timer channel
`timescale 1ns/1ps
`default_nettype none
interface tcp_chan_if;
  logic [15:0] cnt;
  logic        step;
  logic        ovf;
  logic        center;
  logic [7:0]  wdata;
  logic        wr_sc, wr_vh, wr_vl, rd_sc;
  logic [7:0]  sc, vh, vl;
  logic        irq;
  logic        pin_in, gpio_d, gpio_dir, pue;
  logic        pin_out, pin_oe, pin_pu;
  modport top (output cnt, step, ovf, center, wdata, wr_sc, wr_vh, wr_vl, rd_sc,
               output pin_in, gpio_d, gpio_dir, pue,
               input sc, vh, vl, irq, pin_out, pin_oe, pin_pu);
  modport chan (input cnt, step, ovf, center, wdata, wr_sc, wr_vh, wr_vl, rd_sc,
                input pin_in, gpio_d, gpio_dir, pue,
                output sc, vh, vl, irq, pin_out, pin_oe, pin_pu);
endinterface : tcp_chan_if
`default_nettype wire

/* File: src/tcp_channel.sv */
// One capture, compare or PWM channel of the timer
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module tcp_channel
  import tcp_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  // Counter side
  tcp_chan_if.chan  ch
);
  logic        flag_r, arm_r, ie_r;
  logic [1:0]  ms_r, edge_r;
  logic [7:0]  hbuf_r;
  logic [15:0] val_r, act_r;
  logic        s1_r, s2_r, s3_r, lvl_r;
  tcp_mode_t   mode;
  logic        used, ctl, rise, fall, cap, match, cmp;

  assign mode  = tcp_mode(ch.center, ms_r);
  assign used  = (edge_r != 2'b00);
  assign ctl   = used && (mode != TCP_M_CAPTURE);
  assign rise  = s2_r && !s3_r;
  assign fall  = !s2_r && s3_r;
  assign cap   = (mode == TCP_M_CAPTURE) && ((edge_r[0] && rise) || (edge_r[1] && fall)); // [RL8]
  assign match = ch.step && (ch.cnt == act_r) && (mode != TCP_M_CAPTURE);
  assign cmp   = (ch.cnt < act_r);

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s1_r <= 1'b0; s2_r <= 1'b0; s3_r <= 1'b0;
    end else begin
      s1_r <= ch.pin_in; s2_r <= s1_r; s3_r <= s2_r;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ie_r <= 1'b0; ms_r <= 2'b00; edge_r <= 2'b00;
    end else if (ch.wr_sc) begin
      ie_r   <= ch.wdata[`TCP_CS_IE];
      ms_r   <= ch.wdata[`TCP_CS_MS +: 2];   // [RL6]
      edge_r <= ch.wdata[`TCP_CS_EDGE +: 2];
    end
  end

  // Event wins over a clear landing in the same cycle
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      flag_r <= 1'b0; arm_r <= 1'b0;
    end else if (cap || match) begin
      flag_r <= 1'b1; arm_r <= 1'b0;
    end else if (ch.wr_sc) begin
      if (arm_r && !ch.wdata[`TCP_CS_FLAG])
        flag_r <= 1'b0;
      arm_r <= 1'b0;
    end else if (ch.rd_sc && flag_r) begin
      arm_r <= 1'b1;
    end
  end

  // Active compare value reloads at period end in PWM modes only
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      hbuf_r <= `TCP_RST_BYTE; val_r <= `TCP_RST_WORD; act_r <= `TCP_RST_WORD;
    end else begin
      if (cap)
        val_r <= ch.cnt;
      else if (ch.wr_vl)
        val_r <= {hbuf_r, ch.wdata};
      if (ch.wr_vh)
        hbuf_r <= ch.wdata;
      if (ch.ovf || mode == TCP_M_COMPARE || mode == TCP_M_CAPTURE)
        act_r <= val_r;                       // [RL7]
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lvl_r <= 1'b0;
    end else begin
      case (mode)
        TCP_M_COMPARE: begin
          if (match) begin
            case (edge_r)                     // [RL9]
              2'b01:   lvl_r <= !lvl_r;
              2'b10:   lvl_r <= 1'b0;
              2'b11:   lvl_r <= 1'b1;
              default: lvl_r <= lvl_r;        // [RL18]
            endcase
          end
        end
        TCP_M_EPWM, TCP_M_CENTER: lvl_r <= edge_r[0] ? !cmp : cmp; // [RL10]
        default: lvl_r <= lvl_r;
      endcase
    end
  end

  assign ch.pin_out = ctl ? lvl_r : ch.gpio_d;      // [RL19] [RL20]
  assign ch.pin_oe  = ctl ? 1'b1 : (used ? 1'b0 : ch.gpio_dir);
  assign ch.pin_pu  = ch.pue && used && (mode == TCP_M_CAPTURE); // [RL14]
  assign ch.irq     = flag_r && ie_r;                // [RL11]
  assign ch.sc      = {flag_r, ie_r, ms_r, edge_r, 2'b00};
  assign ch.vh      = val_r[15:8];
  assign ch.vl      = val_r[7:0];
endmodule : tcp_channel
`default_nettype wire

/* File: src/tcp_timer.sv */
// Timer top: shared counter, prescaler, clock select, registers, channels
//
// Operation
// RL1: Prescaler divides the selected clock by 1, 2, 4 ... 128.
// RL2: One 16-bit counter, up in normal mode, up/down in center mode.
// RL3: Modulus limits range; all zeros or all ones run free.
// RL4: Counter reads never disturb counting.
// RL5: Any write to either counter byte clears the counter.
// RL6: Each channel independently capture, compare or edge PWM.
// RL7: Buffered center PWM applies to all channels together.
// RL8: Capture on rising, falling or both edges per channel.
// RL9: Compare match sets, clears or toggles the channel output.
// RL10: PWM output polarity selectable per channel.
// RL11: One interrupt per channel plus one overflow interrupt.
// RL12: Clock source selectable: bus rate, fixed system clock, external pin.
// RL13: After reset block disabled, pins plain inputs, pullups off.
// RL14: Pullup may be enabled on a pin used as timer input.
// RL15: Source select 1:1 drives prescaler from external clock pin.
// RL16: External clock synchronized to bus clock; below quarter bus rate.
// RL17: Software leaves edge select 0:0 on a channel sharing clock pin.
// RL18: A channel without pin still works as software compare timer.
// RL19: Channel needing no pin returns it to general purpose I/O.
// RL20: Port data and direction ignored while timer owns the pin.
// RL21: Source codes: off, bus rate, fixed clock, external pin.
// RL22: Overflow flag on wrap after modulus; center mode on step down.
// RL23: Overflow clears by read with flag set, then write zero.
// RL24: Center select forces up/down counting and center PWM channels.
// RL25: One counter step per prescaler tick; no counting when off.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module tcp_timer
  import tcp_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  // Register port
  input  wire logic [7:0]        addr_in,
  input  wire logic [7:0]        wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic      [7:0]        rdata_out,
  // Count clock inputs and external clock pin pullup
  input  wire logic              fixed_clk_in,
  input  wire logic              ext_clk_pin_in,
  output logic                   ext_pu_out,
  // Channel pins
  input  wire logic [NUM_CH-1:0] ch_pin_in,
  input  wire logic [NUM_CH-1:0] gpio_data_in,
  input  wire logic [NUM_CH-1:0] gpio_dir_in,
  output logic      [NUM_CH-1:0] ch_pin_out,
  output logic      [NUM_CH-1:0] ch_pin_oe_out,
  output logic      [NUM_CH-1:0] ch_pu_out,
  // Interrupt requests
  output logic      [NUM_CH-1:0] ch_irq_out,
  output logic                   ovf_irq_out
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  generate
    if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad
      $error("NUM_CH must lie between 1 and 8");
    end
  endgenerate

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic              ovf_r;
  logic              ovf_arm_r;
  logic              ovie_r;
  logic              center_r;
  logic [1:0]        src_r;
  logic [2:0]        ps_r;
  logic [7:0]        pue_r;
  logic [15:0]       cnt_r;
  logic [15:0]       mod_r;
  logic [7:0]        mod_hbuf_r;
  tcp_dir_t          dir_r;
  logic [6:0]        presc_r;
  logic              step_r;
  logic              wrap_r;
  logic [7:0]        rdata_r;
  logic [7:0]        rd_nxt;
  logic              fx1_r, fx2_r, fx3_r;
  logic              ex1_r, ex2_r, ex3_r;
  logic              src_tick;
  logic              presc_tick;
  logic [6:0]        presc_mask;
  logic [15:0]       top;
  logic              wrap_evt;
  logic              wr_sc, rd_sc, cnt_wr;
  logic [7:0]        sc_val;
  logic [7:0]        ch_sc  [NUM_CH];
  logic [7:0]        ch_vh  [NUM_CH];
  logic [7:0]        ch_vl  [NUM_CH];
  tcp_src_t          src;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic ch_hit(input logic [7:0] a, input int idx, input logic [1:0] sub);
    logic [7:0] base;
    base = 8'(`TCP_A_CH0 + idx * `TCP_CH_STRIDE);
    return (a == 8'(base + {6'h00, sub}));
  endfunction : ch_hit

  assign wr_sc  = wr_in && (addr_in == `TCP_A_SC);
  assign rd_sc  = rd_in && (addr_in == `TCP_A_SC);
  assign cnt_wr = wr_in && (addr_in == `TCP_A_CNTH || addr_in == `TCP_A_CNTL); // [RL5]

  // ----------------------------------------
  // Clock source synchronizers
  // ----------------------------------------
  // Three stages: two to settle, third only for edge detection
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      fx1_r <= 1'b0;
      fx2_r <= 1'b0;
      fx3_r <= 1'b0;
      ex1_r <= 1'b0;
      ex2_r <= 1'b0;
      ex3_r <= 1'b0;
    end else begin
      fx1_r <= fixed_clk_in;
      fx2_r <= fx1_r;
      fx3_r <= fx2_r;
      ex1_r <= ext_clk_pin_in;          // [RL16]
      ex2_r <= ex1_r;
      ex3_r <= ex2_r;
    end
  end

  assign src = tcp_src_t'(src_r);

  // Sources at or above half bus rate lose edges here
  always_comb begin
    case (src)                          // [RL12] [RL21]
      TCP_SRC_OFF:   src_tick = 1'b0;
      TCP_SRC_BUS:   src_tick = 1'b1;
      TCP_SRC_FIXED: src_tick = fx2_r && !fx3_r;
      TCP_SRC_EXT:   src_tick = ex2_r && !ex3_r; // [RL15]
      default:       src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  assign presc_mask = 7'(7'h7F >> (3'h7 - ps_r));
  assign presc_tick = src_tick && ((presc_r & presc_mask) == presc_mask); // [RL1]

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      presc_r <= 7'h00;
    end else if (cnt_wr) begin
      presc_r <= 7'h00;
    end else if (src_tick) begin
      presc_r <= 7'(presc_r + 7'h01);
    end
  end

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  assign top = (mod_r == `TCP_RST_WORD || mod_r == `TCP_CNT_FULL) ? `TCP_CNT_FULL : mod_r; // [RL3]
  assign wrap_evt = presc_tick && !cnt_wr &&
                    (center_r ? (dir_r == TCP_UP && cnt_r >= top) : (cnt_r == top));

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt_r <= `TCP_RST_WORD;
      dir_r <= TCP_UP;
    end else if (cnt_wr) begin
      cnt_r <= `TCP_RST_WORD;
      dir_r <= TCP_UP;
    end else if (!center_r) begin
      dir_r <= TCP_UP;
      if (presc_tick)                   // [RL25]
        cnt_r <= (cnt_r == top) ? `TCP_RST_WORD : 16'(cnt_r + 16'h0001); // [RL2]
    end else if (presc_tick) begin
      case (dir_r)                      // [RL24]
        TCP_UP: begin
          if (cnt_r >= top) begin
            dir_r <= TCP_DOWN;
            cnt_r <= 16'(top - 16'h0001);
          end else begin
            cnt_r <= 16'(cnt_r + 16'h0001);
          end
        end
        TCP_DOWN: begin
          if (cnt_r == `TCP_RST_WORD) begin
            dir_r <= TCP_UP;
            cnt_r <= 16'h0001;
          end else begin
            cnt_r <= 16'(cnt_r - 16'h0001);
          end
        end
        default: dir_r <= TCP_UP;
      endcase
    end
  end

  // Step and wrap strobes lag the tick one cycle, in line with the moved counter
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      step_r <= 1'b0;
      wrap_r <= 1'b0;
    end else begin
      step_r <= presc_tick && !cnt_wr;
      wrap_r <= wrap_evt;
    end
  end

  // ----------------------------------------
  // Overflow flag
  // ----------------------------------------
  // A new overflow restarts the clear sequence and wins over the write
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovf_r     <= 1'b0;
      ovf_arm_r <= 1'b0;
    end else if (wrap_evt) begin
      ovf_r     <= 1'b1;                // [RL22]
      ovf_arm_r <= 1'b0;
    end else if (wr_sc) begin
      if (ovf_arm_r && !wdata_in[`TCP_SC_OVF])
        ovf_r <= 1'b0;                  // [RL23]
      ovf_arm_r <= 1'b0;
    end else if (rd_sc && ovf_r) begin
      ovf_arm_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ovie_r   <= 1'b0;
      center_r <= 1'b0;
      src_r    <= 2'b00;                // [RL13]
      ps_r     <= 3'h0;
    end else if (wr_sc) begin
      ovie_r   <= wdata_in[`TCP_SC_OVIE];
      center_r <= wdata_in[`TCP_SC_CENTER];
      src_r    <= wdata_in[`TCP_SC_SRC +: 2];
      ps_r     <= wdata_in[2:0];
    end
  end

  // Modulus commits as a whole word on the low byte write
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mod_r      <= `TCP_RST_WORD;
      mod_hbuf_r <= `TCP_RST_BYTE;
    end else if (wr_in) begin
      if (addr_in == `TCP_A_MODH)
        mod_hbuf_r <= wdata_in;
      if (addr_in == `TCP_A_MODL)
        mod_r <= {mod_hbuf_r, wdata_in};
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pue_r <= `TCP_RST_BYTE;           // [RL13]
    end else if (wr_in && addr_in == `TCP_A_PUE) begin
      pue_r <= wdata_in;
    end
  end

  // ----------------------------------------
  // Channels
  // ----------------------------------------
  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      tcp_chan_if cif ();
      assign cif.cnt      = cnt_r;
      assign cif.step     = step_r;
      assign cif.ovf      = wrap_r;
      assign cif.center   = center_r;   // [RL7] [RL24]
      assign cif.wdata    = wdata_in;
      assign cif.wr_sc    = wr_in && ch_hit(addr_in, i, `TCP_SUB_SC);
      assign cif.wr_vh    = wr_in && ch_hit(addr_in, i, `TCP_SUB_VH);
      assign cif.wr_vl    = wr_in && ch_hit(addr_in, i, `TCP_SUB_VL);
      assign cif.rd_sc    = rd_in && ch_hit(addr_in, i, `TCP_SUB_SC);
      assign cif.pin_in   = ch_pin_in[i];
      assign cif.gpio_d   = gpio_data_in[i];
      assign cif.gpio_dir = gpio_dir_in[i];
      assign cif.pue      = pue_r[i];
      assign ch_sc[i]     = cif.sc;
      assign ch_vh[i]     = cif.vh;
      assign ch_vl[i]     = cif.vl;
      assign ch_pin_out[i]    = cif.pin_out;
      assign ch_pin_oe_out[i] = cif.pin_oe;
      assign ch_pu_out[i]     = cif.pin_pu;
      assign ch_irq_out[i]    = cif.irq; // [RL11]

      tcp_channel u_ch (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .ch         (cif.chan)
      );
    end
  endgenerate

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  assign sc_val = {ovf_r, ovie_r, center_r, src_r, ps_r};

  always_comb begin
    rd_nxt = `TCP_RST_BYTE;
    case (addr_in)
      `TCP_A_SC:   rd_nxt = sc_val;
      `TCP_A_CNTH: rd_nxt = cnt_r[15:8]; // [RL4]
      `TCP_A_CNTL: rd_nxt = cnt_r[7:0];
      `TCP_A_MODH: rd_nxt = mod_r[15:8];
      `TCP_A_MODL: rd_nxt = mod_r[7:0];
      `TCP_A_PUE:  rd_nxt = pue_r;
      default:     rd_nxt = `TCP_RST_BYTE;
    endcase
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_hit(addr_in, i, `TCP_SUB_SC))
        rd_nxt = ch_sc[i];
      if (ch_hit(addr_in, i, `TCP_SUB_VH))
        rd_nxt = ch_vh[i];
      if (ch_hit(addr_in, i, `TCP_SUB_VL))
        rd_nxt = ch_vl[i];
    end
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata_r <= `TCP_RST_BYTE;
    end else begin
      rdata_r <= rd_in ? rd_nxt : `TCP_RST_BYTE;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_out   = rdata_r;
  assign ovf_irq_out = ovf_r && ovie_r;  // [RL11]
  assign ext_pu_out  = pue_r[7] && (src == TCP_SRC_EXT); // [RL14]

endmodule : tcp_timer
`default_nettype wire

/* File: bench/tcp_timer_monitor.sv */
// Port-level checks for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module tcp_timer_monitor #(
  parameter int NUM_CH = 2
) (
  // Clock and reset
  input wire logic              sys_clk_in,
  input wire logic              sys_rst_in,
  // Register port
  input wire logic [7:0]        addr_in,
  input wire logic [7:0]        wdata_in,
  input wire logic              wr_in,
  input wire logic              rd_in,
  input wire logic [7:0]        rdata_out,
  // Clocks and pins
  input wire logic              fixed_clk_in,
  input wire logic              ext_clk_pin_in,
  input wire logic              ext_pu_out,
  input wire logic [NUM_CH-1:0] ch_pin_in,
  input wire logic [NUM_CH-1:0] gpio_data_in,
  input wire logic [NUM_CH-1:0] gpio_dir_in,
  input wire logic [NUM_CH-1:0] ch_pin_out,
  input wire logic [NUM_CH-1:0] ch_pin_oe_out,
  input wire logic [NUM_CH-1:0] ch_pu_out,
  // Interrupt requests
  input wire logic [NUM_CH-1:0] ch_irq_out,
  input wire logic              ovf_irq_out
);
  // ----
  // Shadow of written control bits
  // ----
  logic [7:0] sc_r;
  logic [7:0] pue_r;
  logic [7:0] csc_r;
  logic       own;
  logic       cap;
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sc_r  <= 8'h00;
      pue_r <= 8'h00;
      csc_r <= 8'h00;
    end else if (wr_in) begin
      if (addr_in == `TCP_A_SC) sc_r <= wdata_in;
      if (addr_in == `TCP_A_PUE) pue_r <= wdata_in;
      if (addr_in == `TCP_A_CH0) csc_r <= wdata_in;
    end
  end
  assign own = csc_r[3:2] != 2'b00 && (sc_r[5] || csc_r[5:4] != 2'b00);
  assign cap = csc_r[3:2] != 2'b00 && !sc_r[5] && csc_r[5:4] == 2'b00;
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_two_sc_reads;
    rd_in && addr_in == `TCP_A_SC ##1 rd_in && addr_in == `TCP_A_SC && rdata_out[7];
  endsequence
  a_read_quiet: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("Read data not zero outside read answer");
  a_ovf_irq_gate: assert property (ovf_irq_out |-> sc_r[6])
    else $error("Overflow request while disabled");
  a_ch_irq_gate: assert property (ch_irq_out[0] |-> csc_r[6])
    else $error("Channel request while disabled");
  a_ext_pullup: assert property (ext_pu_out == (pue_r[7] && sc_r[4:3] == 2'b11))
    else $error("Clock pin pullup wrong");
  a_cap_pullup: assert property (ch_pu_out[0] == (pue_r[0] && cap))
    else $error("Channel pullup wrong");
  a_pin_owned: assert property (own |-> ch_pin_oe_out[0])
    else $error("Owned pin not driven");
  a_cap_input: assert property (cap |-> !ch_pin_oe_out[0])
    else $error("Capture pin driven");
  a_pin_released: assert property (csc_r[3:2] == 2'b00 |->
    ch_pin_oe_out[0] == gpio_dir_in[0] && ch_pin_out[0] == gpio_data_in[0])
    else $error("Released pin not under port control");
  a_cnt_clear: assert property (wr_in && (addr_in == `TCP_A_CNTH || addr_in == `TCP_A_CNTL)
    ##1 rd_in && addr_in == `TCP_A_CNTH |=> rdata_out == 8'h00)
    else $error("Counter not cleared by write");
  a_flag_sticky: assert property (s_two_sc_reads |=> rdata_out[7])
    else $error("Overflow flag dropped without a write");
  c_ovf_irq: cover property (ovf_irq_out);
  c_ch_irq: cover property (ch_irq_out[0]);
  c_cap_pu: cover property (ch_pu_out[0] && ext_pu_out);
endmodule : tcp_timer_monitor
bind tcp_timer tcp_timer_monitor #(.NUM_CH(NUM_CH)) i_mon (.*);
`default_nettype wire

/* File: bench/tcp_pins_model.sv */
// Far-side model: count clock pins and channel pin levels
`timescale 1ns/1ps
`default_nettype none
module tcp_pins_model #(
  parameter int NUM_CH = 2
) (
  // Bus clock
  input  wire logic              sys_clk_in,
  // Pins
  output logic                   ext_clk_out,
  output logic                   fixed_clk_out,
  output logic      [NUM_CH-1:0] ch_pin_out
);
  // Clock pins rest low between bursts; the clock pin is not a channel pin
  initial begin
    ext_clk_out = 1'b0;
    fixed_clk_out = 1'b0;
    ch_pin_out = '0;
  end
  // Eight bus cycles a period stays under a quarter of the bus rate
  task automatic burst(input logic ext, input int n);
    repeat (n) begin
      repeat (4) @(posedge sys_clk_in);
      {ext_clk_out, fixed_clk_out} <= ext ? 2'b10 : 2'b01;
      repeat (4) @(posedge sys_clk_in);
      {ext_clk_out, fixed_clk_out} <= 2'b00;
    end
  endtask : burst
  task automatic set_pin(input int i, input logic v);
    @(posedge sys_clk_in);
    ch_pin_out[i] <= v;
  endtask : set_pin
endmodule : tcp_pins_model
`default_nettype wire

/* File: bench/tcp_timer_bench.sv */
// Self-checking bench for the timer block
`timescale 1ns/1ps
`default_nettype none
`include "tcp_defines.svh"
module tcp_timer_bench;
  logic        sys_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [1:0]  gpio_data_in = 2'h1;
  logic [1:0]  gpio_dir_in = 2'h2;
  logic        fixed_clk_in, ext_clk_pin_in, ext_pu_out, ovf_irq_out;
  logic [1:0]  ch_pin_in, ch_pin_out, ch_pin_oe_out, ch_pu_out, ch_irq_out;
  logic [7:0]  rdata_out, q;
  logic [15:0] v, w;
  logic [7:0]  ra [6] = '{`TCP_A_SC, `TCP_A_CNTH, `TCP_A_MODL, `TCP_A_CH0, 8'h14, 8'h3F};
  int          n_errors = 0;
  int          checks = 0;
  always #2 sys_clk_in = ~sys_clk_in;
  tcp_timer #(.NUM_CH(2)) i_dut (.*);
  tcp_pins_model #(.NUM_CH(2)) i_pins (.sys_clk_in(sys_clk_in), .ext_clk_out(ext_clk_pin_in),
    .fixed_clk_out(fixed_clk_in), .ch_pin_out(ch_pin_in));
  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Strobes stay as set until the next call, so every sequence ends idle
  task automatic cyc(input logic wi, input logic ri, input logic [7:0] a, input logic [7:0] d);
    wr_in <= wi;
    rd_in <= ri;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
  endtask : cyc
  task automatic idle(input int n);
    repeat (n) cyc(1'b0, 1'b0, 8'h00, 8'h00);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d);
    idle(1);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    cyc(1'b0, 1'b1, a, 8'h00);
    idle(1);
    q = rdata_out;
  endtask : rd
  task automatic rd16(input logic [7:0] a);
    cyc(1'b0, 1'b1, a, 8'h00);
    cyc(1'b0, 1'b1, a + 8'h01, 8'h00);
    v[15:8] = rdata_out;
    idle(1);
    v[7:0] = rdata_out;
  endtask : rd16
  task automatic cap_chk(input logic e);
    int k;
    q = 8'h00;
    if (e) begin
      for (k = 0; k < 16 && q[7] !== 1'b1; k++) rd(`TCP_A_CH0);
    end else begin
      idle(8);
      rd(`TCP_A_CH0);
    end
    chk({q[7], ch_irq_out[0]}, {e, e});
  endtask : cap_chk
  // ----
  // Tests
  // ----
  initial begin
    repeat (16) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge sys_clk_in);
    wr(8'h3F, 8'hA5);
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(q, 8'h00);
    end
    chk({ch_pin_oe_out, ch_pin_out, ch_pu_out, ovf_irq_out, ext_pu_out}, 8'h90);
    $display("reset test done");
    for (int ps = 0; ps < 8; ps++) begin
      wr(`TCP_A_SC, {5'b00001, ps[2:0]});
      cyc(1'b1, 1'b0, `TCP_A_CNTH, 8'hFF);
      cyc(1'b0, 1'b1, `TCP_A_CNTH, 8'h00);
      idle(100);
      rd16(`TCP_A_CNTH);
      idle(151);
      wr(`TCP_A_SC, 8'h00);
      rd16(`TCP_A_CNTH);
      w = 16'd256 >> ps;
      chk(v + 16'd2 >= w && v <= w + 16'd2, 1'b1);
      w = v;
      idle(4);
      rd16(`TCP_A_CNTH);
      chk(v, w);
    end
    $display("prescaler test done");
    wr(`TCP_A_MODH, 8'h00);
    wr(`TCP_A_MODL, 8'h09);
    wr(`TCP_A_PUE, 8'h81);
    wr(`TCP_A_SC, 8'h48);
    idle(12);
    chk(ovf_irq_out, 1'b1);
    rd16(`TCP_A_CNTH);
    chk(v <= 16'h0009, 1'b1);
    wr(`TCP_A_SC, 8'h40);
    rd(`TCP_A_SC);
    chk(q, 8'hC0);
    wr(`TCP_A_SC, 8'hC0);
    cyc(1'b0, 1'b1, `TCP_A_SC, 8'h00);
    rd(`TCP_A_SC);
    chk(q, 8'hC0);
    wr(`TCP_A_SC, 8'h40);
    rd(`TCP_A_SC);
    chk({q, 7'h00, ovf_irq_out}, 16'h4000);
    wr(`TCP_A_CH0, 8'h08);
    wr(`TCP_A_SC, 8'h28);
    idle(30);
    rd(`TCP_A_SC);
    chk({q[7], ch_pin_oe_out[0]}, 2'b11);
    rd16(`TCP_A_CNTH);
    chk(v <= 16'h0009, 1'b1);
    $display("overflow test done");
    for (int s = 2; s < 4; s++) begin
      wr(`TCP_A_SC, {3'b000, s[1:0], 3'b000});
      wr(`TCP_A_CNTH, 8'h00);
      chk(ext_pu_out, s[0]);
      fork
        i_pins.burst(s[0], 5);
        idle(48);
      join
      rd16(`TCP_A_CNTH);
      chk(v, 16'h0005);
    end
    $display("clock source test done");
    wr(`TCP_A_SC, 8'h08);
    // Arms the clear of a flag left over from center mode
    rd(`TCP_A_CH0);
    for (int e = 1; e < 4; e++) begin
      wr(`TCP_A_CH0, {4'b0100, e[1:0], 2'b00});
      i_pins.set_pin(0, 1'b1);
      cap_chk(e[0]);
      wr(`TCP_A_CH0, {4'b0100, e[1:0], 2'b00});
      i_pins.set_pin(0, 1'b0);
      cap_chk(e[1]);
      wr(`TCP_A_CH0, {4'b0100, e[1:0], 2'b00});
    end
    $display("capture test done");
    wr(`TCP_A_MODL, 8'h20);
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h10);
    gpio_data_in <= 2'b00;
    wr(8'h14, 8'h1C);
    idle(40);
    chk({ch_pin_oe_out[1], ch_pin_out[1]}, 2'b11);
    gpio_data_in <= 2'b10;
    wr(8'h14, 8'h18);
    idle(40);
    chk({ch_pin_oe_out[1], ch_pin_out[1]}, 2'b10);
    wr(8'h14, 8'h14);
    idle(40);
    w = ch_pin_out[1];
    idle(33);
    chk(ch_pin_out[1], !w[0]);
    rd(8'h14);
    wr(8'h14, 8'h10);
    idle(40);
    rd(8'h14);
    chk(q[7], 1'b1);
    chk({ch_pin_oe_out[1], ch_pin_out[1]}, {gpio_dir_in[1], gpio_data_in[1]});
    $display("compare test done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h15, 8'h00);
      wr(8'h16, k[1] ? 8'h21 : 8'h00);
      gpio_data_in <= {!(k[1] ^ k[0]), 1'b0};
      wr(8'h14, k[0] ? 8'h24 : 8'h28);
      idle(40);
      chk(ch_pin_out[1], k[1] ^ k[0]);
    end
    $display("pwm test done");
    print_verdict();
  end
endmodule : tcp_timer_bench
`default_nettype wire
